// File: logic/fasp_pkg.sv
// shared constants, register map and types of the fifo serial port
package fasp_pkg;
  localparam int FASP_AW = 8;
  localparam logic [7:0] FASP_A_MODE = 8'h00;
  localparam logic [7:0] FASP_A_CTRL = 8'h04;
  localparam logic [7:0] FASP_A_BAUD = 8'h08;
  localparam logic [7:0] FASP_A_TXDATA = 8'h0C;
  localparam logic [7:0] FASP_A_RXDATA = 8'h10;
  localparam logic [7:0] FASP_A_STATUS = 8'h14;
  localparam logic [7:0] FASP_A_COUNT = 8'h18;
  localparam logic [1:0] FASP_RESP_OKAY = 2'h0;
  localparam logic [1:0] FASP_RESP_SLVERR = 2'h2;
  localparam int FASP_DEPTH = 16;
  localparam logic [4:0] FASP_FULL = 5'h10;
  localparam logic [4:0] FASP_RTS_LEVEL = 5'h0F;
  localparam logic [7:0] FASP_IDLE_BITS = 8'h0F;
  localparam logic FASP_HAS_MODEM = 1'b1;
  localparam logic [7:0] FASP_BAUD_RST = 8'hFF;
  localparam logic [3:0] FASP_OS16_LAST = 4'hF;
  localparam logic [3:0] FASP_OS8_LAST = 4'h7;
  localparam logic [3:0] FASP_HALF16_LAST = 4'h7;
  localparam logic [3:0] FASP_HALF8_LAST = 4'h3;
  localparam logic [5:0] FASP_PRE_DIV1 = 6'h00;
  localparam logic [5:0] FASP_PRE_DIV4 = 6'h03;
  localparam logic [5:0] FASP_PRE_DIV16 = 6'h0F;
  localparam logic [5:0] FASP_PRE_DIV64 = 6'h3F;
  localparam logic [4:0] FASP_TX_THR0 = 5'h08;
  localparam logic [4:0] FASP_TX_THR1 = 5'h04;
  localparam logic [4:0] FASP_TX_THR2 = 5'h02;
  localparam logic [4:0] FASP_TX_THR3 = 5'h00;
  localparam logic [4:0] FASP_RX_THR0 = 5'h01;
  localparam logic [4:0] FASP_RX_THR1 = 5'h04;
  localparam logic [4:0] FASP_RX_THR2 = 5'h08;
  localparam logic [4:0] FASP_RX_THR3 = 5'h0E;
  // status bit positions
  localparam int FASP_S_TX_EMPTY = 0;
  localparam int FASP_S_RX_FULL = 1;
  localparam int FASP_S_RX_READY = 2;
  localparam int FASP_S_BREAK = 3;
  localparam int FASP_S_OVERRUN = 4;
  localparam int FASP_S_FAULT = 5;
  localparam int FASP_S_TX_END = 6;
  localparam logic [6:0] FASP_STATUS_RST = 7'h01;

  typedef struct packed {
    logic clk_stop;
    logic modem_en;
    logic dbl_speed;
    logic base8;
    logic ext_div8;
    logic ext_clk;
    logic [1:0] clk_div;
    logic stop2;
    logic par_odd;
    logic par_en;
    logic char7;
  } fasp_mode_t;

  typedef struct packed {
    logic dma_mode;
    logic [1:0] tx_trigger_level;
    logic [1:0] rx_trigger_level;
    logic rx_fifo_rst;
    logic tx_fifo_rst;
    logic rx_irq_en;
    logic tx_irq_en;
    logic rx_en;
    logic tx_en;
  } fasp_ctrl_t;

  typedef enum logic [2:0] {
    FASP_IDLE, FASP_START, FASP_DATA, FASP_PAR, FASP_STOP
  } fasp_state_t;
endpackage

// File: logic/fasp_core.sv
// fifo async serial port channel with axi4-lite register slave
module fasp_core import fasp_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [FASP_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [FASP_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd,
  input wire logic sck,
  input wire logic cts_n,
  input wire logic tx_dma_ack,
  input wire logic rx_dma_ack,
  output logic txd,
  output logic rts_n,
  output logic tx_request_irq,
  output logic rx_request_irq,
  output logic line_break_irq,
  output logic rx_error_irq,
  output logic tx_dma_req,
  output logic rx_dma_req
);
  fasp_mode_t mode_r;
  fasp_ctrl_t ctrl_r;
  logic [7:0] baud_r;
  logic [6:0] st_r;
  logic [7:0] txf [FASP_DEPTH];
  logic [9:0] rxf [FASP_DEPTH];
  logic [3:0] txw_r, txr_r, rxw_r, rxr_r;
  logic [4:0] txc_r, rxc_r, rxe_r;
  logic aw_held_r, w_held_r;
  logic [FASP_AW-1:0] awa_r;
  logic [31:0] wd_r;
  logic [3:0] ws_r;
  logic [31:0] rd_c;
  logic rd_ok_c, wr_ok_c, do_wr, rd_go;
  logic [31:0] wmask;
  logic tx_push, tx_pop, rx_push, rx_pop, rx_ovr, rx_pop_d_r;
  logic [5:0] pre_r, pre_last;
  logic [7:0] br_r;
  logic pre_hit, sck_q_r, base_tick, run;
  logic [3:0] os_last, half_last;
  fasp_state_t tx_st_r, rx_st_r;
  logic [3:0] tx_os_r, rx_os_r;
  logic [2:0] tx_bit_r, rx_bit_r, nb_last;
  logic [7:0] tx_sh_r, rx_sh_r, tx_din, rx_data_c;
  logic tx_par_r, txd_r, cts_ok, rxd_q_r, rx_pbit_r;
  logic rx_smp, rx_fe_c, rx_pe_c, rx_brk_c;
  logic [4:0] tx_thr, rx_thr;
  logic tx_empty_cond, tx_empty_q_r, rx_full_cond, rx_full_q_r;
  logic [7:0] to_r, to_lim;
  logic [6:0] clr, set;

  assign run = ~mode_r.clk_stop;
  assign do_wr = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign rd_go = s_axi_arvalid & s_axi_arready;
  assign wmask = {{8{ws_r[3]}}, {8{ws_r[2]}}, {8{ws_r[1]}}, {8{ws_r[0]}}};
  assign wr_ok_c = awa_r inside {FASP_A_MODE, FASP_A_CTRL, FASP_A_BAUD,
    FASP_A_TXDATA, FASP_A_RXDATA, FASP_A_STATUS, FASP_A_COUNT};

  // ---------------- axi4-lite slave ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awa_r <= '0;
      wd_r <= '0;
      ws_r <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= FASP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awa_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wd_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok_c ? FASP_RESP_OKAY : FASP_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_c = '0;
    rd_ok_c = 1'b1;
    case (s_axi_araddr)
      FASP_A_MODE: rd_c[11:0] = mode_r;
      FASP_A_CTRL: rd_c[10:0] = ctrl_r;
      FASP_A_BAUD: rd_c[7:0] = baud_r;
      FASP_A_TXDATA: rd_c = '0;
      FASP_A_RXDATA: rd_c[9:0] = rxf[rxr_r];
      FASP_A_STATUS: rd_c[6:0] = st_r;
      FASP_A_COUNT: rd_c[20:0] = {rxe_r, 3'h0, rxc_r, 3'h0, txc_r};
      default: rd_ok_c = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= FASP_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= (s_axi_araddr == FASP_A_RXDATA && rxc_r == 5'h00)
        ? 32'h0000_0000 : rd_c;
      s_axi_rresp <= rd_ok_c ? FASP_RESP_OKAY : FASP_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- control registers ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= '0;
      ctrl_r <= '0;
      baud_r <= FASP_BAUD_RST;
    end else if (do_wr) begin
      case (awa_r)
        FASP_A_MODE:
          mode_r <= (mode_r & ~wmask[11:0]) | (wd_r[11:0] & wmask[11:0]);
        FASP_A_CTRL:
          ctrl_r <= (ctrl_r & ~wmask[10:0]) | (wd_r[10:0] & wmask[10:0]);
        FASP_A_BAUD:
          if (ws_r[0]) baud_r <= wd_r[7:0];
        default: ;
      endcase
    end
  end

  // ---------------- baud generator ----------------
  always_comb begin
    case (mode_r.clk_div)
      2'h0: pre_last = FASP_PRE_DIV1;
      2'h1: pre_last = FASP_PRE_DIV4;
      2'h2: pre_last = FASP_PRE_DIV16;
      default: pre_last = FASP_PRE_DIV64;
    endcase
  end
  assign pre_hit = pre_r == pre_last;
  // 16x or 8x base, external divide picks the same way
  assign os_last = (mode_r.ext_clk ? mode_r.ext_div8 : mode_r.base8)
    ? FASP_OS8_LAST : FASP_OS16_LAST;
  assign half_last = (os_last == FASP_OS8_LAST)
    ? FASP_HALF8_LAST : FASP_HALF16_LAST;
  // each rising pin edge is one base tick
  // a stopped clock freezes every tick below
  assign base_tick = run & (mode_r.ext_clk ? (sck & ~sck_q_r)
    : (pre_hit & br_r == 8'h00));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_r <= '0;
      br_r <= '0;
      sck_q_r <= 1'b0;
    end else begin
      sck_q_r <= sck;
      if (run && !mode_r.ext_clk) begin
        pre_r <= pre_hit ? 6'h00 : pre_r + 6'h01;
        // double speed halves the reload, internal only
        if (pre_hit)
          br_r <= (br_r != 8'h00) ? br_r - 8'h01
            : (mode_r.dbl_speed ? {1'b0, baud_r[7:1]} : baud_r);
      end
    end
  end

  // ---------------- transmitter ----------------
  // cts gates only the start of a new frame
  assign cts_ok = ~(FASP_HAS_MODEM & mode_r.modem_en) | ~cts_n;
  assign tx_din = mode_r.char7 ? {1'b0, txf[txr_r][6:0]} : txf[txr_r];
  assign nb_last = mode_r.char7 ? 3'h6 : 3'h7;
  assign tx_pop = base_tick & ctrl_r.tx_en & (tx_st_r == FASP_IDLE)
    & (txc_r != 5'h00) & cts_ok;
  assign tx_push = do_wr & (awa_r == FASP_A_TXDATA) & ws_r[0]
    & (txc_r != FASP_FULL);

  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl_r.tx_en) begin
      tx_st_r <= FASP_IDLE;
      tx_os_r <= '0;
      tx_bit_r <= '0;
      tx_sh_r <= '0;
      tx_par_r <= 1'b0;
      txd_r <= 1'b1;
    end else if (base_tick) begin
      if (tx_st_r == FASP_IDLE || tx_os_r == os_last) tx_os_r <= 4'h0;
      else tx_os_r <= tx_os_r + 4'h1;
      case (tx_st_r)
        FASP_IDLE:
          if (tx_pop) begin
            tx_sh_r <= tx_din;
            tx_par_r <= ^tx_din ^ mode_r.par_odd;
            txd_r <= 1'b0;
            tx_st_r <= FASP_START;
          end
        FASP_START:
          if (tx_os_r == os_last) begin
            txd_r <= tx_sh_r[0];
            tx_bit_r <= 3'h0;
            tx_st_r <= FASP_DATA;
          end
        FASP_DATA:
          if (tx_os_r == os_last) begin
            if (tx_bit_r == nb_last) begin
              txd_r <= mode_r.par_en ? tx_par_r : 1'b1;
              tx_bit_r <= 3'h0;
              tx_st_r <= mode_r.par_en ? FASP_PAR : FASP_STOP;
            end else begin
              tx_sh_r <= {1'b0, tx_sh_r[7:1]};
              txd_r <= tx_sh_r[1];
              tx_bit_r <= tx_bit_r + 3'h1;
            end
          end
        FASP_PAR:
          if (tx_os_r == os_last) begin
            txd_r <= 1'b1;
            tx_st_r <= FASP_STOP;
          end
        FASP_STOP:
          if (tx_os_r == os_last) begin
            if (mode_r.stop2 && tx_bit_r == 3'h0) tx_bit_r <= 3'h1;
            else tx_st_r <= FASP_IDLE;
          end
        default: tx_st_r <= FASP_IDLE;
      endcase
    end
  end

  // ---------------- receiver ----------------
  assign rx_smp = base_tick & (rx_st_r == FASP_STOP) & (rx_os_r == os_last);
  assign rx_data_c = mode_r.char7 ? {1'b0, rx_sh_r[7:1]} : rx_sh_r;
  assign rx_fe_c = ~rxd;
  assign rx_pe_c = mode_r.par_en & (rx_pbit_r ^ ^rx_data_c ^ mode_r.par_odd);
  // all-space frame with bad stop is a break
  assign rx_brk_c = rx_fe_c & (rx_data_c == 8'h00)
    & ~(mode_r.par_en & rx_pbit_r);
  assign rx_push = rx_smp & ~rx_brk_c & (rxc_r != FASP_FULL);
  // overrun when no slot is free
  assign rx_ovr = rx_smp & ~rx_brk_c & (rxc_r == FASP_FULL);
  assign rx_pop = rd_go & (s_axi_araddr == FASP_A_RXDATA) & (rxc_r != 5'h00);

  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl_r.rx_en) begin
      rx_st_r <= FASP_IDLE;
      rx_os_r <= '0;
      rx_bit_r <= '0;
      rx_sh_r <= '0;
      rx_pbit_r <= 1'b0;
      rxd_q_r <= 1'b1;
    end else if (base_tick) begin
      rxd_q_r <= rxd;
      if (rx_st_r == FASP_IDLE || rx_os_r == os_last ||
          (rx_st_r == FASP_START && rx_os_r == half_last))
        rx_os_r <= 4'h0;
      else rx_os_r <= rx_os_r + 4'h1;
      case (rx_st_r)
        FASP_IDLE:
          if (rxd_q_r && !rxd) rx_st_r <= FASP_START;
        // verify start at half a bit
        FASP_START:
          if (rx_os_r == half_last) begin
            rx_bit_r <= 3'h0;
            rx_st_r <= rxd ? FASP_IDLE : FASP_DATA;
          end
        FASP_DATA:
          if (rx_os_r == os_last) begin
            rx_sh_r <= {rxd, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == nb_last)
              rx_st_r <= mode_r.par_en ? FASP_PAR : FASP_STOP;
          end
        FASP_PAR:
          if (rx_os_r == os_last) begin
            rx_pbit_r <= rxd;
            rx_st_r <= FASP_STOP;
          end
        FASP_STOP:
          if (rx_os_r == os_last) rx_st_r <= FASP_IDLE;
        default: rx_st_r <= FASP_IDLE;
      endcase
    end
  end

  // ---------------- fifos ----------------
  always_ff @(posedge aclk) begin
    if (tx_push) txf[txw_r] <= wd_r[7:0];
    // parity and framing kept per entry
    if (rx_push) rxf[rxw_r] <= {rx_fe_c, rx_pe_c, rx_data_c};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || ctrl_r.tx_fifo_rst) begin
      txw_r <= '0;
      txr_r <= '0;
      txc_r <= '0;
    end else begin
      if (tx_push) txw_r <= txw_r + 4'h1;
      if (tx_pop) txr_r <= txr_r + 4'h1;
      txc_r <= txc_r + {4'h0, tx_push} - {4'h0, tx_pop};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || ctrl_r.rx_fifo_rst) begin
      rxw_r <= '0;
      rxr_r <= '0;
      rxc_r <= '0;
      rxe_r <= '0;
    end else begin
      if (rx_push) rxw_r <= rxw_r + 4'h1;
      if (rx_pop) rxr_r <= rxr_r + 4'h1;
      rxc_r <= rxc_r + {4'h0, rx_push} - {4'h0, rx_pop};
      rxe_r <= rxe_r + {4'h0, rx_push & (rx_fe_c | rx_pe_c)}
        - {4'h0, rx_pop & (rxf[rxr_r][9:8] != 2'h0)};
    end
  end

  // ---------------- flags ----------------
  always_comb begin
    case (ctrl_r.tx_trigger_level)
      2'h0: tx_thr = FASP_TX_THR0;
      2'h1: tx_thr = FASP_TX_THR1;
      2'h2: tx_thr = FASP_TX_THR2;
      default: tx_thr = FASP_TX_THR3;
    endcase
    case (ctrl_r.rx_trigger_level)
      2'h0: rx_thr = FASP_RX_THR0;
      2'h1: rx_thr = FASP_RX_THR1;
      2'h2: rx_thr = FASP_RX_THR2;
      default: rx_thr = FASP_RX_THR3;
    endcase
  end
  assign tx_empty_cond = txc_r <= tx_thr;
  assign rx_full_cond = rxc_r >= rx_thr;
  assign to_lim = 8'(({4'h0, os_last} + 8'h01) * FASP_IDLE_BITS);

  // quiet line with data below trigger
  always_ff @(posedge aclk) begin
    if (!aresetn || rx_st_r != FASP_IDLE || rx_push || rx_pop ||
        rxc_r == 5'h00 || rx_full_cond)
      to_r <= '0;
    else if (base_tick && to_r != to_lim)
      to_r <= to_r + 8'h01;
  end

  always_comb begin
    clr = '0;
    if (do_wr && awa_r == FASP_A_STATUS && ws_r[0]) clr = wd_r[6:0];
    clr[FASP_S_TX_EMPTY] = clr[FASP_S_TX_EMPTY] | tx_dma_ack;
    // dma ack clears full and ready
    clr[FASP_S_RX_FULL] = clr[FASP_S_RX_FULL] | rx_dma_ack;
    clr[FASP_S_RX_READY] = clr[FASP_S_RX_READY] | rx_dma_ack;
    clr[FASP_S_TX_END] = 1'b1;
    set = '0;
    set[FASP_S_TX_EMPTY] = tx_empty_cond & ~tx_empty_q_r;
    // re-arm after each pop so a draining reader keeps being called
    set[FASP_S_RX_FULL] = rx_full_cond & (~rx_full_q_r | rx_pop_d_r);
    set[FASP_S_RX_READY] = base_tick & (to_r == to_lim - 8'h01)
      & ~rx_full_cond & (rx_st_r == FASP_IDLE) & (rxc_r != 5'h00);
    set[FASP_S_BREAK] = rx_smp & rx_brk_c;
    set[FASP_S_OVERRUN] = rx_ovr;
    set[FASP_S_FAULT] = rx_push & (rx_fe_c | rx_pe_c);
    set[FASP_S_TX_END] = (tx_st_r == FASP_IDLE) & (txc_r == 5'h00);
  end

  // events landing with a clear win
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= FASP_STATUS_RST;
      tx_empty_q_r <= 1'b1;
      rx_full_q_r <= 1'b0;
      rx_pop_d_r <= 1'b0;
    end else begin
      st_r <= set | (st_r & ~clr);
      tx_empty_q_r <= tx_empty_cond;
      rx_full_q_r <= rx_full_cond;
      rx_pop_d_r <= rx_pop;
    end
  end

  // ---------------- outputs ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd <= 1'b1;
      rts_n <= 1'b1;
      tx_request_irq <= 1'b0;
      rx_request_irq <= 1'b0;
      line_break_irq <= 1'b0;
      rx_error_irq <= 1'b0;
      tx_dma_req <= 1'b0;
      rx_dma_req <= 1'b0;
    end else begin
      txd <= txd_r;
      // rts drops back when rx fifo nearly full
      rts_n <= ~(FASP_HAS_MODEM & mode_r.modem_en) | (rxc_r >= FASP_RTS_LEVEL);
      tx_request_irq <= ctrl_r.tx_irq_en & ~ctrl_r.dma_mode
        & st_r[FASP_S_TX_EMPTY];
      tx_dma_req <= ctrl_r.tx_irq_en & ctrl_r.dma_mode
        & st_r[FASP_S_TX_EMPTY];
      rx_request_irq <= ctrl_r.rx_irq_en & ~ctrl_r.dma_mode
        & (st_r[FASP_S_RX_FULL] | st_r[FASP_S_RX_READY]);
      rx_dma_req <= ctrl_r.rx_irq_en & ctrl_r.dma_mode
        & (st_r[FASP_S_RX_FULL] | st_r[FASP_S_RX_READY]);
      line_break_irq <= ctrl_r.rx_irq_en
        & (st_r[FASP_S_BREAK] | st_r[FASP_S_OVERRUN]);
      rx_error_irq <= ctrl_r.rx_irq_en & st_r[FASP_S_FAULT];
    end
  end
endmodule

// File: verification/fasp_core_assertions.sv
// checker of bus handshake and serial line relations of the port
module fasp_core_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic txd,
  input wire logic rts_n,
  input wire logic tx_dma_ack,
  input wire logic tx_request_irq,
  input wire logic rx_request_irq,
  input wire logic line_break_irq,
  input wire logic tx_dma_req,
  input wire logic rx_dma_req
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // reset has no disable: it checks what reset itself leaves behind
  property p_rst_idle;
    disable iff (1'b0) !aresetn |=> txd && rts_n && !tx_request_irq;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("line not idle after reset");
  property p_start_len;
    $fell(txd) |-> !txd [*8];
  endproperty
  a_start_len: assert property (p_start_len)
    else $error("start bit too short");
  property p_tx_dma;
    tx_dma_req |-> !tx_request_irq;
  endproperty
  a_tx_dma: assert property (p_tx_dma)
    else $error("tx request shown as irq in dma mode");
  property p_rx_dma;
    rx_dma_req |-> !rx_request_irq;
  endproperty
  a_rx_dma: assert property (p_rx_dma)
    else $error("rx request shown as irq in dma mode");
  property p_tx_ack;
    tx_dma_ack && tx_dma_req |-> ##[1:3] !tx_dma_req;
  endproperty
  a_tx_ack: assert property (p_tx_ack)
    else $error("tx dma ack did not clear request");
  property p_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
  endproperty
  a_w_take: assert property (p_w_take)
    else $error("write response timing wrong");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
  endproperty
  a_b_done: assert property (p_b_done)
    else $error("write response not retired");
  property p_r_take;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_take: assert property (p_r_take)
    else $error("read data timing wrong");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_r_done: assert property (p_r_done)
    else $error("read response not retired");
  c_frame: cover property ($fell(txd));
  c_rx: cover property (rx_request_irq);
  c_brk: cover property (line_break_irq);
  c_dma: cover property (tx_dma_ack && tx_dma_req);
endmodule

bind fasp_core fasp_core_assertions fasp_core_assertions_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .txd, .rts_n,
  .tx_dma_ack, .tx_request_irq, .rx_request_irq, .line_break_irq,
  .tx_dma_req, .rx_dma_req
);

// File: verification/fasp_remote.sv
// model of the remote terminal, 16 clocks per bit
module fasp_remote (
  input wire logic aclk,
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got = 8'h00;
  int got_cnt = 0;
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] d, input logic par_on,
                      input logic par_v, input logic stop_v);
    logic [10:0] f;
    f = {stop_v, par_v, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || par_on) begin
        rxd <= f[i];
        repeat (16) @(posedge aclk);
      end
    end
    rxd <= 1'b1;
    @(posedge aclk);
  endtask
  initial forever begin
    @(negedge txd);
    repeat (8) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge aclk);
      got[i] = txd;
    end
    repeat (16) @(posedge aclk);
    got_cnt++;
  end
endmodule

// File: verification/test_fifo_async_serial_port.sv
// self-checking bench of the fifo serial port channel
module test_fifo_async_serial_port import fasp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic cts_n = 1'b0, tx_dma_ack = 1'b0, rx_dma_ack = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rxd, txd, rts_n, tx_request_irq, rx_request_irq;
  logic line_break_irq, rx_error_irq, tx_dma_req, rx_dma_req;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  int err_count = 0, compares = 0, cycles = 0;

  always #12.5 aclk = ~aclk;

  fasp_core fasp_core_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd,
    .sck(1'b0), .cts_n, .tx_dma_ack, .rx_dma_ack, .txd, .rts_n,
    .tx_request_irq, .rx_request_irq, .line_break_irq, .rx_error_irq,
    .tx_dma_req, .rx_dma_req
  );
  fasp_remote fasp_remote_i (.aclk, .txd, .rxd);

  task finish_test;
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // whole run needs well under twenty thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic chk_reg(input string n, input logic [7:0] a,
                         input logic [31:0] m, input logic [31:0] e);
    rd_reg(a);
    chk(n, e, rd & m);
  endtask

  task automatic t_reset;
    chk_reg("status", FASP_A_STATUS, 32'h0000_003F, 32'h0000_0001);
    chk_reg("count", FASP_A_COUNT, 32'hFFFF_FFFF, 32'h0000_0000);
    chk("txd", 32'h0000_0001, {31'h0, txd});
    chk("rts_n", 32'h0000_0001, {31'h0, rts_n});
    rd_reg(8'h1C);
    chk("unmapped resp", {30'h0, FASP_RESP_SLVERR}, {30'h0, rs});
    chk("unmapped data", 32'h0000_0000, rd);
  endtask

  task automatic t_tx;
    int n;
    wr(FASP_A_BAUD, 32'h0000_0000);
    wr(FASP_A_CTRL, 32'h0000_0005);
    repeat (2) @(posedge aclk);
    chk("tx irq", 32'h0000_0001, {31'h0, tx_request_irq});
    n = fasp_remote_i.got_cnt;
    wr(FASP_A_TXDATA, 32'h0000_00A5);
    for (int i = 0; i < 400 && fasp_remote_i.got_cnt == n; i++)
      @(posedge aclk);
    chk("tx char", 32'h0000_00A5, {24'h0, fasp_remote_i.got});
  endtask

  task automatic t_rx;
    wr(FASP_A_CTRL, 32'h0000_000F);
    fasp_remote_i.send(8'h3C, 1'b0, 1'b0, 1'b1);
    repeat (30) @(posedge aclk);
    chk("rx irq", 32'h0000_0001, {31'h0, rx_request_irq});
    chk_reg("rx count", FASP_A_COUNT, 32'h0000_1F00, 32'h0000_0100);
    chk_reg("rx data", FASP_A_RXDATA, 32'h0000_03FF, 32'h0000_003C);
  endtask

  task automatic t_par;
    wr(FASP_A_MODE, 32'h0000_0002);
    fasp_remote_i.send(8'h07, 1'b1, 1'b1, 1'b1);
    fasp_remote_i.send(8'h07, 1'b1, 1'b0, 1'b1);
    repeat (30) @(posedge aclk);
    chk("err irq", 32'h0000_0001, {31'h0, rx_error_irq});
    chk_reg("par ok", FASP_A_RXDATA, 32'h0000_03FF, 32'h0000_0007);
    chk_reg("par bad", FASP_A_RXDATA, 32'h0000_03FF, 32'h0000_0107);
  endtask

  // seven data bits, odd parity, two stop bits
  task automatic t_fmt;
    wr(FASP_A_MODE, 32'h0000_000F);
    // parity rides in the eighth slot of the model frame
    fasp_remote_i.send(8'hD5, 1'b0, 1'b0, 1'b1);
    repeat (30) @(posedge aclk);
    chk_reg("char7", FASP_A_RXDATA, 32'h0000_03FF, 32'h0000_0055);
  endtask

  task automatic t_brk;
    wr(FASP_A_MODE, 32'h0000_0000);
    fasp_remote_i.send(8'h00, 1'b0, 1'b0, 1'b0);
    repeat (30) @(posedge aclk);
    chk_reg("break", FASP_A_STATUS, 32'h0000_0008, 32'h0000_0008);
    chk("brk irq", 32'h0000_0001, {31'h0, line_break_irq});
  endtask

  task automatic t_dma;
    wr(FASP_A_CTRL, 32'h0000_040F);
    repeat (2) @(posedge aclk);
    chk("tx dma", 32'h0000_0001, {31'h0, tx_dma_req});
    chk("tx irq", 32'h0000_0000, {31'h0, tx_request_irq});
    chk("rx dma", 32'h0000_0001, {31'h0, rx_dma_req});
    tx_dma_ack <= 1'b1;
    rx_dma_ack <= 1'b1;
    @(posedge aclk);
    tx_dma_ack <= 1'b0;
    rx_dma_ack <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("tx dma", 32'h0000_0000, {31'h0, tx_dma_req});
    chk("rx dma", 32'h0000_0000, {31'h0, rx_dma_req});
    chk_reg("flags", FASP_A_STATUS, 32'h0000_0007, 32'h0000_0000);
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_par();
    t_fmt();
    t_brk();
    t_dma();
    finish_test();
  end
endmodule
